/* rtl/dcle_pkg.sv */
package dcle_pkg;

  // ---------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD       = 8'h00;
  localparam logic [7:0] OFS_CTRL      = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_ACC       = 8'h0c;
  localparam logic [7:0] OFS_PC        = 8'h10;
  localparam logic [7:0] OFS_STACK_TOP = 8'h14;
  localparam logic [7:0] OFS_PORT_ADDR = 8'h18;
  localparam logic [7:0] OFS_MEM_ADDR  = 8'h1c;
  localparam logic [7:0] OFS_MEM_DATA  = 8'h20;
  localparam logic [2:0] OFS_AR_BLOCK  = 3'h2;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int SB_BUSY = 0;
  localparam int SB_IDLE = 1;
  localparam int SB_TC   = 2;
  localparam int SB_GLOBAL_IRQ_MASK = 3;
  localparam int SB_SXM  = 4;
  localparam int SB_CNF  = 5;
  localparam int SB_ARP  = 8;
  localparam int CB_SXM  = 0;
  localparam int CB_TREG = 4;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] ACC_RST  = 32'h0000_0000;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic        GLOBAL_IRQ_MASK_RST = 1'b1;
  localparam logic        SXM_RST  = 1'b1;
  localparam logic        CNF_RST  = 1'b0;
  localparam logic [2:0]  ARP_RST  = 3'h0;

  // ---------------------------------------------------------------------
  // on-chip ram map
  // ---------------------------------------------------------------------
  localparam logic [15:0] B2_LO      = 16'h0060;
  localparam logic [15:0] B2_HI      = 16'h007f;
  localparam logic [15:0] B0_LO      = 16'h0200;
  localparam logic [15:0] B0_HI      = 16'h02ff;
  localparam logic [15:0] B1_LO      = 16'h0300;
  localparam logic [15:0] B1_HI      = 16'h03ff;
  localparam logic [15:0] B0_PROG_LO = 16'hff00;
  localparam logic [15:0] B0_PROG_HI = 16'hffff;
  localparam logic [1:0]  B0_PAGE    = 2'h2;
  localparam int          RAM_WORDS  = 1024;

  // ---------------------------------------------------------------------
  // selector codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] CLR_GLOBAL_IRQ_MASK = 3'h0;
  localparam logic [2:0] CLR_SXM  = 3'h1;
  localparam logic [2:0] CLR_TC   = 3'h2;
  localparam logic [2:0] CLR_CNF  = 3'h3;
  localparam logic [1:0] CMP_EQ   = 2'h0;
  localparam logic [1:0] CMP_LT   = 2'h1;
  localparam logic [1:0] CMP_GT   = 2'h2;
  localparam logic [1:0] CMP_NE   = 2'h3;
  localparam int         COND_EQ  = 0;
  localparam int         COND_LT  = 1;
  localparam int         COND_GT  = 2;
  localparam int         COND_TC  = 3;
  localparam logic [4:0] SOFT_VEC_MAX = 5'h1f;

  typedef enum logic [4:0] {
    OP_NOP    = 5'h00, OP_CCALL  = 5'h01, OP_CLEAR_CONTROL_BIT   = 5'h02,
    OP_ONES_COMPLEMENT_ACC   = 5'h03, OP_AUX_COMPARE_OP   = 5'h04, OP_MAP_BLOCK_TO_DATA   = 5'h05,
    OP_MAP_BLOCK_TO_PROGRAM   = 5'h06, OP_IRQ_DISABLE_OP   = 5'h07, OP_DATA_SHIFT_OP   = 5'h08,
    OP_IRQ_ENABLE_OP   = 5'h09, OP_IDLE   = 5'h0a, OP_PORTIN = 5'h0b,
    OP_SOFT_VECTOR_CALL   = 5'h0c, OP_LACS   = 5'h0d, OP_LACCK  = 5'h0e,
    OP_LOAD_ACC_BYTE   = 5'h0f, OP_LACLD  = 5'h10, OP_LACLK  = 5'h11,
    OP_LOAD_ACC_T_SHIFT   = 5'h12, OP_LARD   = 5'h13, OP_LARK8  = 5'h14,
    OP_LARLK  = 5'h15, OP_LARKS  = 5'h16, OP_LOAD_AUX_POINTER   = 5'h17
  } dcle_op_t;

  typedef enum logic [3:0] {
    ST_READY = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_IO    = 4'b0100,
    ST_HALT  = 4'b1000
  } dcle_state_t;

  typedef struct packed {
    logic [15:0] operand;
    logic [3:0]  cond;
    logic [3:0]  shift;
    logic [2:0]  sel;
    dcle_op_t    op;
  } dcle_cmd_t;

  typedef struct packed {
    logic        ioSelN;
    logic        strobeN;
    logic        rdN;
    logic [15:0] addr;
  } dcle_io_t;

  localparam dcle_io_t IO_IDLE = '{1'b1, 1'b1, 1'b1, 16'h0000};

endpackage

/* rtl/dcle_loader.sv */
module dcle_loader
  import dcle_pkg::*;
(
  // operand and shift
  input  wire logic [15:0] opnd,
  input  wire logic [3:0]  shiftAmt,
  input  wire logic        signExt,
  // value for the accumulator
  output logic [31:0]      result
);

  logic [31:0] widened;

  always_comb begin
    // high bits follow the sign only in sign-extension mode
    widened = {{16{signExt & opnd[15]}}, opnd};
    // vacated low bits are zero filled
    result  = widened << shiftAmt;
  end

endmodule

/* rtl/dcle_core.sv */
// The placing of the registers and the Wishbone interface to the registers were decided locally.
module dcle_core
  import dcle_pkg::*;
#(
  parameter int          STACK_DEPTH = 8,
  parameter logic [15:0] IRQ_VECTOR  = 16'h0002
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic [31:0]      wbDatO,
  output logic             wbAck,
  // io port space
  output dcle_io_t         ioOut,
  input  wire logic [15:0] ioData,
  input  wire logic        ioReady,
  // interrupt request and state
  input  wire logic        irqReq,
  output logic             irqAck,
  output logic             globalIrqMask,
  output logic             idleState
);

  localparam int SPW = $clog2(STACK_DEPTH);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  dcle_state_t  state_ff;
  dcle_cmd_t    cmd_ff;
  logic [31:0]  acc_ff;
  logic [15:0]  aux_ff [0:7];
  logic [2:0]   arp_ff;
  logic         tc_ff;
  logic         global_irq_mask_ff;
  logic         sxm_ff;
  logic         cnf_ff;
  logic [3:0]   treg_ff;
  logic [15:0]  pc_ff;
  logic [15:0]  stack_ff [0:STACK_DEPTH-1];
  logic [SPW-1:0] sp_ff;
  logic [15:0]  portAddr_ff;
  logic [15:0]  memAddr_ff;
  logic [15:0]  dataRam [0:RAM_WORDS-1];
  logic         ack_ff;
  logic [31:0]  datO_ff;
  dcle_io_t     io_ff;
  logic         irqAck_ff;

  logic         wbWr;
  logic         start;
  logic         exec;
  logic         irqTake;
  logic         memOk;
  logic [9:0]   memIdx;
  logic         dmaOk;
  logic         nextOk;
  logic [15:0]  dmaNext;
  logic [15:0]  memRd;
  logic [15:0]  curAr;
  logic         relHolds;
  logic         condOk;
  logic [3:0]   accFlags;
  logic [31:0]  loaded;
  logic         push;
  logic [15:0]  pushVal;

  function automatic logic onChip(input logic [15:0] a, input logic cnf);
    onChip = (a >= B2_LO && a <= B2_HI) || (a >= B1_LO && a <= B1_HI) ||
             (!cnf && a >= B0_LO && a <= B0_HI);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // ---------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------
  // writes land on the edge that ends the handshake
  assign wbWr    = wbCyc & wbStb & wbWe & ack_ff;
  assign irqTake = irqReq & ~global_irq_mask_ff &
                   (state_ff == ST_READY || state_ff == ST_HALT);
  // an accepted interrupt outranks a new command in the same cycle
  assign start   = wbWr && wbAdr == OFS_CMD && state_ff == ST_READY &&
                   !irqTake;
  assign exec    = state_ff == ST_EXEC;

  // program-space alias of block zero when it is mapped there
  always_comb begin
    if (cnf_ff && memAddr_ff >= B0_PROG_LO && memAddr_ff <= B0_PROG_HI) begin
      memOk  = 1'b1;
      memIdx = {B0_PAGE, memAddr_ff[7:0]};
    end else begin
      memOk  = onChip(memAddr_ff, cnf_ff);
      memIdx = memAddr_ff[9:0];
    end
  end

  // ---------------------------------------------------------------------
  // operand fetch and compare
  // ---------------------------------------------------------------------
  assign dmaOk    = onChip(cmd_ff.operand, cnf_ff);
  assign dmaNext  = 16'(cmd_ff.operand + 16'h0001);
  assign nextOk   = onChip(dmaNext, cnf_ff);
  // off-chip data space is not reached here and reads as zero
  assign memRd    = dmaOk ? dataRam[cmd_ff.operand[9:0]] : 16'h0000;
  assign curAr    = aux_ff[arp_ff];
  assign accFlags = {tc_ff, ~acc_ff[31] & (acc_ff != ACC_RST),
                     acc_ff[31], acc_ff == ACC_RST};
  assign condOk   = &(~cmd_ff.cond | accFlags);

  always_comb begin
    unique case (cmd_ff.sel[1:0])
      CMP_EQ:  relHolds = curAr == aux_ff[0];
      CMP_LT:  relHolds = curAr <  aux_ff[0];
      CMP_GT:  relHolds = curAr >  aux_ff[0];
      CMP_NE:  relHolds = curAr != aux_ff[0];
    endcase
  end

  dcle_loader uLoader (
    .opnd     (cmd_ff.op == OP_LACCK ? cmd_ff.operand : memRd),
    .shiftAmt (cmd_ff.op == OP_LOAD_ACC_T_SHIFT ? treg_ff : cmd_ff.shift),
    .signExt  (sxm_ff),
    .result   (loaded)
  );

  // ---------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_READY;
    end else begin
      unique case (state_ff)
        ST_READY: begin
          if (start) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cmd_ff.op == OP_IDLE) begin
            state_ff <= ST_HALT;
          end else if (cmd_ff.op == OP_PORTIN) begin
            state_ff <= ST_IO;
          end else begin
            state_ff <= ST_READY;
          end
        end
        ST_IO: begin
          if (ioReady) begin
            state_ff <= ST_READY;
          end
        end
        ST_HALT: begin
          // masked requests still wake the core, they are just not taken
          if (irqReq) begin
            state_ff <= ST_READY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_ff <= '0;
    end else if (start) begin
      cmd_ff <= merge(cmd_ff, wbDatI, wbSel);
    end
  end

  // ---------------------------------------------------------------------
  // program flow and stack
  // ---------------------------------------------------------------------
  always_comb begin
    push    = 1'b0;
    pushVal = 16'(pc_ff + 16'h0001);
    if (irqTake) begin
      push    = 1'b1;
      pushVal = pc_ff;
    end else if (exec && cmd_ff.op == OP_CCALL && condOk) begin
      push    = 1'b1;
      pushVal = 16'(pc_ff + 16'h0002);
    end else if (exec && cmd_ff.op == OP_SOFT_VECTOR_CALL) begin
      push    = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_ff <= PC_RST;
      sp_ff <= '0;
    end else begin
      if (push) begin
        sp_ff <= SPW'(sp_ff + 1'b1);
      end
      if (irqTake) begin
        pc_ff <= IRQ_VECTOR;
      end else if (exec) begin
        unique case (cmd_ff.op)
          OP_CCALL: begin
            pc_ff <= condOk ? cmd_ff.operand
                            : 16'(pc_ff + 16'h0002);
          end
          OP_SOFT_VECTOR_CALL: begin
            pc_ff <= {10'h000, cmd_ff.operand[4:0] & SOFT_VEC_MAX,
                      1'b0};
          end
          OP_LACCK, OP_LARLK, OP_PORTIN: begin
            pc_ff <= 16'(pc_ff + 16'h0002);
          end
          default: begin
            pc_ff <= 16'(pc_ff + 16'h0001);
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      stack_ff[sp_ff] <= pushVal;
    end
  end

  // ---------------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      global_irq_mask_ff <= GLOBAL_IRQ_MASK_RST;
      sxm_ff  <= SXM_RST;
      cnf_ff  <= CNF_RST;
      tc_ff   <= 1'b0;
      treg_ff <= 4'h0;
    end else begin
      if (wbWr && wbAdr == OFS_CTRL && wbSel[0]) begin
        sxm_ff  <= wbDatI[CB_SXM];
        treg_ff <= wbDatI[CB_TREG +: 4];
      end
      if (irqTake) begin
        global_irq_mask_ff <= 1'b1;
      end else if (exec) begin
        unique case (cmd_ff.op)
          OP_CLEAR_CONTROL_BIT: begin
            unique case (cmd_ff.sel)
              CLR_GLOBAL_IRQ_MASK: global_irq_mask_ff <= 1'b0;
              CLR_SXM:  sxm_ff  <= 1'b0;
              CLR_TC:   tc_ff   <= 1'b0;
              CLR_CNF:  cnf_ff  <= 1'b0;
              default:  ;
            endcase
          end
          OP_AUX_COMPARE_OP:  tc_ff   <= relHolds;
          OP_MAP_BLOCK_TO_DATA:  cnf_ff  <= 1'b0;
          OP_MAP_BLOCK_TO_PROGRAM:  cnf_ff  <= 1'b1;
          OP_IRQ_DISABLE_OP:  global_irq_mask_ff <= 1'b1;
          OP_IRQ_ENABLE_OP:  global_irq_mask_ff <= 1'b0;
          default:  ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // accumulator and auxiliary registers
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_ff <= ACC_RST;
    end else if (exec) begin
      unique case (cmd_ff.op)
        OP_ONES_COMPLEMENT_ACC:               acc_ff <= ~acc_ff;
        OP_LACS, OP_LACCK:     acc_ff <= loaded;
        OP_LOAD_ACC_T_SHIFT:               acc_ff <= loaded;
        OP_LOAD_ACC_BYTE:               acc_ff <= {24'h0, cmd_ff.operand[7:0]};
        OP_LACLD:              acc_ff <= {16'h0, memRd};
        OP_LACLK:              acc_ff <= {24'h0, cmd_ff.operand[7:0]};
        default:               ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arp_ff <= ARP_RST;
      for (int i = 0; i < 8; i++) begin
        aux_ff[i] <= 16'h0000;
      end
    end else if (exec) begin
      unique case (cmd_ff.op)
        OP_LARD:  aux_ff[cmd_ff.sel] <= memRd;
        OP_LARK8: aux_ff[cmd_ff.sel] <= {8'h0, cmd_ff.operand[7:0]};
        OP_LARLK: aux_ff[cmd_ff.sel] <= cmd_ff.operand;
        OP_LARKS: aux_ff[cmd_ff.sel] <= {8'h0, cmd_ff.operand[7:0]};
        OP_LOAD_AUX_POINTER:  arp_ff <= cmd_ff.sel;
        default:  ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // on-chip data ram
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wbWr && wbAdr == OFS_MEM_DATA && memOk && (&wbSel[1:0])) begin
      dataRam[memIdx] <= wbDatI[15:0];
    end
    if (exec && cmd_ff.op == OP_DATA_SHIFT_OP && dmaOk && nextOk) begin
      dataRam[dmaNext[9:0]] <= memRd;
    end
    if (state_ff == ST_IO && ioReady && dmaOk) begin
      dataRam[cmd_ff.operand[9:0]] <= ioData;
    end
  end

  // ---------------------------------------------------------------------
  // io port read
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io_ff <= IO_IDLE;
    end else if (exec && cmd_ff.op == OP_PORTIN) begin
      io_ff <= '{1'b0, 1'b0, 1'b0, portAddr_ff};
    end else if (state_ff == ST_IO && ioReady) begin
      io_ff <= IO_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      portAddr_ff <= 16'h0000;
      memAddr_ff  <= 16'h0000;
    end else if (wbWr) begin
      if (wbAdr == OFS_PORT_ADDR) begin
        portAddr_ff <= 16'(merge({16'h0, portAddr_ff}, wbDatI, wbSel));
      end
      if (wbAdr == OFS_MEM_ADDR) begin
        memAddr_ff <= 16'(merge({16'h0, memAddr_ff}, wbDatI, wbSel));
      end
    end
  end

  // ---------------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff    <= 1'b0;
      datO_ff   <= 32'h0;
      irqAck_ff <= 1'b0;
    end else begin
      ack_ff    <= wbCyc & wbStb & ~ack_ff;
      irqAck_ff <= irqTake;
      datO_ff   <= 32'h0;
      if (wbCyc & wbStb & ~ack_ff & ~wbWe) begin
        if (wbAdr[7:5] == OFS_AR_BLOCK && wbAdr[1:0] == 2'h0) begin
          datO_ff <= {16'h0, aux_ff[wbAdr[4:2]]};
        end else begin
          unique case (wbAdr)
            OFS_CMD:       datO_ff <= cmd_ff;
            OFS_CTRL:      datO_ff <= {24'h0, treg_ff, 3'h0, sxm_ff};
            OFS_STATUS:    datO_ff <= {21'h0, arp_ff, 2'h0, cnf_ff, sxm_ff,
                                       global_irq_mask_ff, tc_ff,
                                       state_ff == ST_HALT,
                                       state_ff != ST_READY};
            OFS_ACC:       datO_ff <= acc_ff;
            OFS_PC:        datO_ff <= {16'h0, pc_ff};
            OFS_STACK_TOP: datO_ff <= {16'h0,
                                       stack_ff[SPW'(sp_ff - 1'b1)]};
            OFS_PORT_ADDR: datO_ff <= {16'h0, portAddr_ff};
            OFS_MEM_ADDR:  datO_ff <= {16'h0, memAddr_ff};
            OFS_MEM_DATA:  datO_ff <= {16'h0,
                                       memOk ? dataRam[memIdx] : 16'h0};
            default:       datO_ff <= 32'h0;
          endcase
        end
      end
    end
  end

  assign wbAck         = ack_ff;
  assign wbDatO        = datO_ff;
  assign ioOut         = io_ff;
  assign irqAck        = irqAck_ff;
  assign globalIrqMask = global_irq_mask_ff;
  // halt bit of the one-hot state register, straight from its flop
  assign idleState     = state_ff[3];

endmodule

/* test/dcle_core_monitor.sv */
module dcle_monitor
  import dcle_pkg::*;
(
  // clock and reset
  input wire logic     mclk,
  input wire logic     rst,
  // register bus
  input wire logic     wbCyc,
  input wire logic     wbStb,
  input wire logic     wbAck,
  // port space
  input wire dcle_io_t ioOut,
  input wire logic     ioReady,
  // interrupt and state
  input wire logic     irqReq,
  input wire logic     irqAck,
  input wire logic     globalIrqMask,
  input wire logic     idleState
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  ack_time_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("ack without request");
  io_lines_a: assert property (!ioOut.ioSelN |-> !ioOut.strobeN && !ioOut.rdN)
    else $error("port read lines not all low");
  io_hold_a: assert property (!ioOut.ioSelN && !ioReady |=>
    !ioOut.ioSelN && $stable(ioOut.addr))
    else $error("port read dropped before ready");
  io_done_a: assert property (!ioOut.ioSelN && ioReady |=> ioOut.ioSelN)
    else $error("port read not released after ready");
  irq_ack_a: assert property (irqAck |-> globalIrqMask ##1 !irqAck)
    else $error("bad interrupt acknowledge");
  mask_block_a: assert property (globalIrqMask [*3] |-> !irqAck)
    else $error("interrupt taken while masked");
  idle_hold_a: assert property (idleState && !irqReq |=> idleState)
    else $error("left idle without interrupt");
endmodule

bind dcle_core dcle_monitor mon (.mclk(mclk), .rst(rst), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbAck(wbAck), .ioOut(ioOut), .ioReady(ioReady),
  .irqReq(irqReq), .irqAck(irqAck), .globalIrqMask(globalIrqMask),
  .idleState(idleState));

/* test/dcle_io_model.sv */
module dcle_io_model
  import dcle_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // port bus
  input  wire dcle_io_t   ioOut,
  input  wire logic [3:0] waitCyc,
  output logic [15:0]     ioData,
  output logic            ioReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  waitCnt_ff;
  logic [15:0] word;

  // data is a fixed function of the port address so the bench can predict it
  assign word = ioOut.addr ^ 16'h5a3c;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitCnt_ff <= 4'h0;
    end else if (ioOut.ioSelN || ioReady) begin
      waitCnt_ff <= 4'h0;
    end else begin
      waitCnt_ff <= waitCnt_ff + 4'h1;
    end
  end
  assign ioReady = !ioOut.ioSelN && (waitCnt_ff == waitCyc);
  // inverted word off the handshake, so stale data never matches
  assign ioData  = ioReady ? word : ~word;
endmodule

/* test/dsp_cc_to_load_aux_pointer_exec_tb.sv */
module dsp_cc_to_load_aux_pointer_exec_tb
  import dcle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] IRQ_VEC = 16'h0040;
  logic        mclk, wbAck, ioReady, irqAck, globalIrqMask, idleState;
  logic        rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic        irqReq = 1'b0, tcx;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0, wbDatO, rdat, v32;
  logic [15:0] ioData, v, pa, p0;
  logic [15:0] arm [8];
  logic [3:0]  waitCyc = 4'h0, sh, t;
  dcle_io_t    ioOut;
  int          err_total = 0, num_checks = 0, k, n, p;
  int          bitPos [4] = '{SB_GLOBAL_IRQ_MASK, SB_SXM, SB_TC, SB_CNF};

  dcle_core #(.IRQ_VECTOR(IRQ_VEC)) dut (.mclk(mclk), .rst(rst),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hf),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .ioOut(ioOut),
    .ioData(ioData), .ioReady(ioReady), .irqReq(irqReq), .irqAck(irqAck),
    .globalIrqMask(globalIrqMask), .idleState(idleState));
  dcle_io_model peer (.mclk(mclk), .rst(rst), .ioOut(ioOut),
    .waitCyc(waitCyc), .ioData(ioData), .ioReady(ioReady));

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbDatI <= d;
    do @(posedge mclk); while (wbAck !== 1'b1);
    rdat = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // polls busy, bounded so a stuck command cannot hang the bench
  task automatic cmd(input dcle_op_t op, input int s, f, c, o);
    wb(1'b1, OFS_CMD, {o[15:0], c[3:0], f[3:0], s[2:0], op});
    n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rdat[SB_BUSY] && n < 40);
    // a command that never finishes counts as a mismatch
    if (rdat[SB_BUSY] !== 1'b0) err_total++;
  endtask
  task automatic mw(input logic [15:0] a, input logic [15:0] d);
    wb(1'b1, OFS_MEM_ADDR, {16'h0, a});
    wb(1'b1, OFS_MEM_DATA, {16'h0, d});
  endtask
  task automatic mr(input logic [15:0] a, input logic [15:0] d);
    wb(1'b1, OFS_MEM_ADDR, {16'h0, a});
    rd(OFS_MEM_DATA, {16'h0, d});
  endtask
  function automatic logic [31:0] ld(logic [15:0] d, int s, logic x);
    return (x ? {{16{d[15]}}, d} : {16'h0, d}) << s;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    stop_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    void'($urandom(92));
    rd(OFS_STATUS, 32'h18);
    rd(OFS_ACC, ACC_RST);
    for (int s = 0; s < 2; s++) begin
      v = $urandom;
      sh = $urandom;
      t = $urandom;
      wb(1'b1, OFS_CTRL, {24'h0, t, 3'h0, s[0]});
      cmd(OP_LACCK, 0, sh, 0, v);
      rd(OFS_ACC, ld(v, sh, s[0]));
      cmd(OP_ONES_COMPLEMENT_ACC, 0, 0, 0, 0);
      rd(OFS_ACC, ~ld(v, sh, s[0]));
      cmd(OP_LOAD_ACC_BYTE, 0, 0, 0, ~v);
      rd(OFS_ACC, {24'h0, ~v[7:0]});
      mw(16'h0300, v);
      cmd(OP_LACS, 0, sh, 0, 16'h0300);
      rd(OFS_ACC, ld(v, sh, s[0]));
      cmd(OP_LOAD_ACC_T_SHIFT, 0, 0, 0, 16'h0300);
      rd(OFS_ACC, ld(v, t, s[0]));
      cmd(OP_LACLD, 0, 0, 0, 16'h0300);
      rd(OFS_ACC, {16'h0, v});
      cmd(OP_LACLK, 0, 0, 0, v);
      rd(OFS_ACC, {24'h0, v[7:0]});
    end
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      cmd(OP_LOAD_AUX_POINTER, i, 0, 0, i);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk({29'h0, rdat[SB_ARP+:3]}, i);
      arm[i] = (i % 2) ? {8'h0, v[7:0]} : v;
      case (i % 4)
        0: begin
          mw(16'h0301, v);
          cmd(OP_LARD, i, 0, 0, 16'h0301);
        end
        1: cmd(OP_LARK8, i, 0, 0, v);
        2: cmd(OP_LARLK, i, 0, 0, v);
        default: cmd(OP_LARKS, i, 0, 0, v);
      endcase
      rd(8'h40 + 8'(4 * i), {16'h0, arm[i]});
    end
    for (int j = 0; j < 2; j++) begin
      p = j ? 0 : 7;
      cmd(OP_LOAD_AUX_POINTER, p, 0, 0, p);
      for (int m = 0; m < 4; m++) begin
        cmd(OP_AUX_COMPARE_OP, m, 0, 0, 0);
        tcx = m == 0 ? arm[p] == arm[0] : m == 1 ? arm[p] < arm[0] :
              m == 2 ? arm[p] > arm[0] : arm[p] != arm[0];
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, rdat[SB_TC]}, {31'h0, tcx});
      end
      rd(8'h40 + 8'(4 * p), {16'h0, arm[p]});
    end
    cmd(OP_IRQ_DISABLE_OP, 0, 0, 0, 0);
    chk({31'h0, globalIrqMask}, 32'h1);
    cmd(OP_IRQ_ENABLE_OP, 0, 0, 0, 0);
    chk({31'h0, globalIrqMask}, 32'h0);
    cmd(OP_IRQ_DISABLE_OP, 0, 0, 0, 0);
    cmd(OP_MAP_BLOCK_TO_PROGRAM, 0, 0, 0, 0);
    wb(1'b0, OFS_STATUS, 32'h0);
    v32 = rdat;
    for (int m = 0; m < 4; m++) begin
      cmd(OP_CLEAR_CONTROL_BIT, m, 0, 0, 0);
      v32[bitPos[m]] = 1'b0;
      rd(OFS_STATUS, v32);
    end
    v = $urandom;
    cmd(OP_MAP_BLOCK_TO_PROGRAM, 0, 0, 0, 0);
    mw(16'hff05, v);
    mr(16'h0205, 16'h0);
    cmd(OP_MAP_BLOCK_TO_DATA, 0, 0, 0, 0);
    mr(16'h0205, v);
    mw(16'h0320, ~v);
    cmd(OP_DATA_SHIFT_OP, 0, 0, 0, 16'h0320);
    mr(16'h0321, ~v);
    for (int i = 0; i < 3; i++) begin
      pa = $urandom;
      waitCyc <= (i == 2) ? 4'hf : 4'($urandom);
      wb(1'b1, OFS_PORT_ADDR, {16'h0, pa});
      cmd(OP_PORTIN, 0, 0, 0, 16'h0330);
      mr(16'h0330, pa ^ 16'h5a3c);
    end
    for (int i = 0; i < 3; i++) begin
      k = i ? $urandom % 32 : 31;
      cmd(OP_SOFT_VECTOR_CALL, 0, 0, 0, k);
      rd(OFS_PC, 2 * k);
    end
    cmd(OP_LOAD_ACC_BYTE, 0, 0, 0, 0);
    wb(1'b0, OFS_PC, 32'h0);
    p0 = rdat[15:0];
    cmd(OP_CCALL, 0, 0, 1, v);
    rd(OFS_PC, {16'h0, v});
    rd(OFS_STACK_TOP, {16'h0, p0 + 16'h2});
    cmd(OP_LOAD_ACC_BYTE, 0, 0, 0, 5);
    wb(1'b0, OFS_PC, 32'h0);
    p0 = rdat[15:0];
    cmd(OP_CCALL, 0, 0, 3, ~v);
    rd(OFS_PC, {16'h0, p0 + 16'h2});
    cmd(OP_IRQ_ENABLE_OP, 0, 0, 0, 0);
    wb(1'b1, OFS_CMD, {27'h0, OP_IDLE});
    repeat (3) @(posedge mclk);
    chk({31'h0, idleState}, 32'h1);
    irqReq <= 1'b1;
    n = 0;
    while (irqAck !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    irqReq <= 1'b0;
    rd(OFS_PC, {16'h0, IRQ_VEC});
    chk({30'h0, idleState, globalIrqMask}, 32'h1);
    stop_test();
  end
endmodule
